// ---- hdl/pcc_defines.svh ----
`ifndef PCC_DEFINES_SVH
`define PCC_DEFINES_SVH
// What this block does
// - Gap bytes between generated frames, reset 0x7d
// - 16-bit received byte counter, holds at 0xffff
// - 32-bit received frame counter in two halves
// - Frame counter holds at all ones unless wrapping
// - Flags bit 0 write snapshots counters only
// - Flags bit 1 write snapshots then clears
// - Done flag set when all frames sent
// - Busy flag high while generator runs
// - Sticky frame overflow, cleared only by clear
// - Sticky byte overflow, cleared only by clear
// - Lock bit shows checker synchronisation
// - 8-bit bit error counter, holds at 0xff
// - 32-bit errored frame counter in two halves
// - Wrap mode pulses and restarts at maximum
// - Send trigger clears itself when done sets
`define PCC_OFF_CTRL 12'h619
`define PCC_OFF_GAP 12'h61b
`define PCC_OFF_BYTES 12'h61c
`define PCC_OFF_FRM_LO 12'h61d
`define PCC_OFF_FRM_HI 12'h61e
`define PCC_OFF_FLAGS 12'h620
`define PCC_OFF_ERRF_LO 12'h622
`define PCC_OFF_ERRF_HI 12'h623
`define PCC_OFF_IRQ_STAT 12'h630
`define PCC_OFF_IRQ_EN 12'h631
`define PCC_OFF_IRQ_CLR 12'h632
`define PCC_GAP_RESET 8'h7d
`define PCC_CTRL_SEND_BIT 12
`define PCC_CTRL_MODE_BIT 3
`define PCC_CTRL_CHK_EN_BIT 2
`define PCC_CHK_EN_RESET 1'b1
`define PCC_FLAG_DONE_BIT 12
`define PCC_FLAG_BUSY_BIT 11
`define PCC_FLAG_FOV_BIT 10
`define PCC_FLAG_BOV_BIT 9
`define PCC_FLAG_LOCK_BIT 8
`define PCC_SNAP_BIT 0
`define PCC_SNAP_CLR_BIT 1
`define PCC_IRQ_W 7
`define PCC_IRQ_FRM_OVF 0
`define PCC_IRQ_BYTE_OVF 1
`define PCC_IRQ_ERRF_OVF 2
`define PCC_IRQ_BIT_OVF 3
`define PCC_IRQ_DONE 4
`define PCC_IRQ_LOCK_UP 5
`define PCC_IRQ_LOCK_DOWN 6
`endif

// ---- hdl/pcc_pkg.sv ----
package pcc_pkg;
	typedef struct packed {
		logic byte_valid;
		logic frame_end;
		logic frame_err;
		logic bit_err;
		logic lock;
	} pcc_chk_evt_t;

	typedef struct packed {
		logic [15:0] frame_len;
		logic [15:0] frame_count;
	} pcc_gen_cfg_t;

	typedef enum logic [1:0] {
		PCC_GEN_IDLE = 2'b00,
		PCC_GEN_DATA = 2'b01,
		PCC_GEN_GAP = 2'b10
	} pcc_gen_state_t;
endpackage: pcc_pkg

// ---- hdl/pcc_sat_counter.sv ----
`timescale 1ns/1ps

module pcc_sat_counter #(
	parameter int W = 16
) (
	input logic clk,
	input logic rst,
	input logic inc,
	input logic clr,
	input logic wrap,
	output logic [W-1:0] count_reg,
	output logic ovf
);
	// Clear beats a coincident increment; the overflow still reports
	always_ff @(posedge clk) begin
		if (rst) begin
			count_reg <= '0;
		end else if (clr) begin
			count_reg <= '0;
		end else if (inc && ((count_reg != '1) || wrap)) begin
			count_reg <= count_reg + W'(1);
		end
	end

	assign ovf = inc && (count_reg == '1);
endmodule: pcc_sat_counter

// ---- hdl/pcc_frame_gen.sv ----
`timescale 1ns/1ps

module pcc_frame_gen (
	input logic clk,
	input logic rst,
	input logic start,
	input logic stop,
	input pcc_pkg::pcc_gen_cfg_t cfg,
	input logic [7:0] gap,
	input logic byte_ready,
	output logic byte_valid_reg,
	output logic byte_last_reg,
	output logic busy_reg,
	output logic done_reg
);
	pcc_pkg::pcc_gen_state_t state_reg;
	pcc_pkg::pcc_gen_state_t state_next;
	logic [15:0] byte_cnt_reg;
	logic [15:0] frame_cnt_reg;
	logic [7:0] gap_cnt_reg;
	logic [15:0] len_m1;
	logic [15:0] count_m1;
	logic byte_take;
	logic frame_end;
	logic all_sent;

	// A zero length or count behaves as one
	assign len_m1 = (cfg.frame_len == 16'h0000) ? 16'h0000 :
		cfg.frame_len - 16'h0001;
	assign count_m1 = (cfg.frame_count == 16'h0000) ? 16'h0000 :
		cfg.frame_count - 16'h0001;
	assign byte_take = byte_valid_reg && byte_ready;
	assign frame_end = byte_take && (byte_cnt_reg == len_m1);
	assign all_sent = frame_end && (frame_cnt_reg == count_m1);

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			pcc_pkg::PCC_GEN_IDLE: begin
				if (start) begin
					state_next = pcc_pkg::PCC_GEN_DATA;
				end
			end
			pcc_pkg::PCC_GEN_DATA: begin
				if (stop || all_sent) begin
					state_next = pcc_pkg::PCC_GEN_IDLE;
				end else if (frame_end && (gap != 8'h00)) begin
					state_next = pcc_pkg::PCC_GEN_GAP;
				end
			end
			pcc_pkg::PCC_GEN_GAP: begin
				if (stop) begin
					state_next = pcc_pkg::PCC_GEN_IDLE;
				end else if (gap_cnt_reg >= gap - 8'h01) begin
					state_next = pcc_pkg::PCC_GEN_DATA;
				end
			end
			default: begin
				state_next = pcc_pkg::PCC_GEN_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_reg <= pcc_pkg::PCC_GEN_IDLE;
			byte_valid_reg <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			byte_valid_reg <= (state_next == pcc_pkg::PCC_GEN_DATA);
			busy_reg <= (state_next != pcc_pkg::PCC_GEN_IDLE);
		end
	end

	always_ff @(posedge clk) begin
		if (rst || (state_reg == pcc_pkg::PCC_GEN_IDLE)) begin
			byte_cnt_reg <= 16'h0000;
			frame_cnt_reg <= 16'h0000;
		end else if (frame_end) begin
			byte_cnt_reg <= 16'h0000;
			frame_cnt_reg <= frame_cnt_reg + 16'h0001;
		end else if (byte_take) begin
			byte_cnt_reg <= byte_cnt_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (rst || (state_reg != pcc_pkg::PCC_GEN_GAP)) begin
			gap_cnt_reg <= 8'h00;
		end else begin
			gap_cnt_reg <= gap_cnt_reg + 8'h01;
		end
	end

	// Last marker follows the byte about to be offered
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_last_reg <= 1'b0;
		end else if (state_next != pcc_pkg::PCC_GEN_DATA) begin
			byte_last_reg <= 1'b0;
		end else if (byte_take || (state_reg != pcc_pkg::PCC_GEN_DATA)) begin
			byte_last_reg <= frame_end ? (len_m1 == 16'h0000) :
				((state_reg != pcc_pkg::PCC_GEN_DATA) ?
				(len_m1 == 16'h0000) : (byte_cnt_reg + 16'h0001 == len_m1));
		end
	end

	// Done drops at start and rises only after a complete run
	always_ff @(posedge clk) begin
		if (rst) begin
			done_reg <= 1'b0;
		end else if ((state_reg == pcc_pkg::PCC_GEN_IDLE) && start) begin
			done_reg <= 1'b0;
		end else if ((state_reg == pcc_pkg::PCC_GEN_DATA) && all_sent &&
			!stop) begin
			done_reg <= 1'b1;
		end
	end
endmodule: pcc_frame_gen

// ---- hdl/pcc_checker_status.sv ----
`timescale 1ns/1ps
`include "pcc_defines.svh"

module pcc_checker_status (
	input logic clk,
	input logic rst,
	input logic [11:0] reg_addr,
	input logic [15:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	output logic [15:0] reg_rdata_reg,
	input pcc_pkg::pcc_chk_evt_t chk_evt,
	input pcc_pkg::pcc_gen_cfg_t gen_cfg,
	input logic tx_byte_ready,
	output logic tx_byte_valid_reg,
	output logic tx_byte_last_reg,
	output logic cnt_wrap_reg,
	output logic irq_reg
);
	logic wr_ctrl;
	logic wr_gap;
	logic wr_flags;
	logic wr_irq_en;
	logic wr_irq_clr;
	logic snap_req;
	logic snap_clr;

	logic send_reg;
	logic mode_reg;
	logic chk_en_reg;
	logic start_reg;
	logic stop_reg;
	logic [7:0] gap_reg;

	logic byte_inc;
	logic frame_inc;
	logic errf_inc;
	logic bit_inc;
	logic [15:0] byte_live;
	logic [31:0] frame_live;
	logic [31:0] errf_live;
	logic [7:0] bit_live;
	logic byte_ovf;
	logic frame_ovf;
	logic errf_ovf;
	logic bit_ovf;

	logic [15:0] byte_snap_reg;
	logic [31:0] frame_snap_reg;
	logic [31:0] errf_snap_reg;
	logic [7:0] bit_snap_reg;
	logic frame_ovf_flag_reg;
	logic byte_ovf_flag_reg;

	logic lock_reg;
	logic lock_d_reg;
	logic gen_busy;
	logic gen_done;
	logic done_d_reg;
	logic done_rise;

	logic [`PCC_IRQ_W-1:0] irq_evt;
	logic [`PCC_IRQ_W-1:0] irq_stat_reg;
	logic [`PCC_IRQ_W-1:0] irq_en_reg;
	logic [`PCC_IRQ_W-1:0] irq_clr_mask;
	logic [15:0] rd_next;

	// Register bus decode
	assign wr_ctrl = reg_wr && (reg_addr == `PCC_OFF_CTRL);
	assign wr_gap = reg_wr && (reg_addr == `PCC_OFF_GAP);
	assign wr_flags = reg_wr && (reg_addr == `PCC_OFF_FLAGS);
	assign wr_irq_en = reg_wr && (reg_addr == `PCC_OFF_IRQ_EN);
	assign wr_irq_clr = reg_wr && (reg_addr == `PCC_OFF_IRQ_CLR);

	// A clear request always carries a snapshot with it
	assign snap_clr = wr_flags && reg_wdata[`PCC_SNAP_CLR_BIT];
	assign snap_req = wr_flags &&
		(reg_wdata[`PCC_SNAP_BIT] || snap_clr);

	// Control bits
	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg <= 1'b0;
			chk_en_reg <= `PCC_CHK_EN_RESET;
		end else if (wr_ctrl) begin
			mode_reg <= reg_wdata[`PCC_CTRL_MODE_BIT];
			chk_en_reg <= reg_wdata[`PCC_CTRL_CHK_EN_BIT];
		end
	end

	// Software write wins over the self-clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			send_reg <= 1'b0;
		end else if (wr_ctrl) begin
			send_reg <= reg_wdata[`PCC_CTRL_SEND_BIT];
		end else if (done_rise) begin
			send_reg <= 1'b0;
		end
	end

	// Rewriting one while running does not restart the generator
	always_ff @(posedge clk) begin
		if (rst) begin
			start_reg <= 1'b0;
			stop_reg <= 1'b0;
		end else begin
			start_reg <= wr_ctrl && reg_wdata[`PCC_CTRL_SEND_BIT] &&
				!send_reg;
			stop_reg <= wr_ctrl && !reg_wdata[`PCC_CTRL_SEND_BIT] &&
				send_reg;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			gap_reg <= `PCC_GAP_RESET;
		end else if (wr_gap) begin
			gap_reg <= reg_wdata[7:0];
		end
	end

	pcc_frame_gen u_gen (
		.clk(clk),
		.rst(rst),
		.start(start_reg),
		.stop(stop_reg),
		.cfg(gen_cfg),
		.gap(gap_reg),
		.byte_ready(tx_byte_ready),
		.byte_valid_reg(tx_byte_valid_reg),
		.byte_last_reg(tx_byte_last_reg),
		.busy_reg(gen_busy),
		.done_reg(gen_done)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			done_d_reg <= 1'b0;
		end else begin
			done_d_reg <= gen_done;
		end
	end

	assign done_rise = gen_done && !done_d_reg;

	// Nothing counts while the checker is disabled
	assign byte_inc = chk_en_reg && chk_evt.byte_valid;
	assign frame_inc = chk_en_reg && chk_evt.frame_end;
	assign errf_inc = chk_en_reg && chk_evt.frame_end &&
		chk_evt.frame_err;
	assign bit_inc = chk_en_reg && chk_evt.bit_err;

	pcc_sat_counter #(
		.W(16)
	) u_byte_cnt (
		.clk(clk),
		.rst(rst),
		.inc(byte_inc),
		.clr(snap_clr),
		.wrap(mode_reg),
		.count_reg(byte_live),
		.ovf(byte_ovf)
	);

	pcc_sat_counter #(
		.W(32)
	) u_frame_cnt (
		.clk(clk),
		.rst(rst),
		.inc(frame_inc),
		.clr(snap_clr),
		.wrap(mode_reg),
		.count_reg(frame_live),
		.ovf(frame_ovf)
	);

	pcc_sat_counter #(
		.W(32)
	) u_errf_cnt (
		.clk(clk),
		.rst(rst),
		.inc(errf_inc),
		.clr(snap_clr),
		.wrap(mode_reg),
		.count_reg(errf_live),
		.ovf(errf_ovf)
	);

	pcc_sat_counter #(
		.W(8)
	) u_bit_cnt (
		.clk(clk),
		.rst(rst),
		.inc(bit_inc),
		.clr(snap_clr),
		.wrap(mode_reg),
		.count_reg(bit_live),
		.ovf(bit_ovf)
	);

	// Readers see only snapshots, so a split 32-bit read never tears
	always_ff @(posedge clk) begin
		if (rst) begin
			byte_snap_reg <= 16'h0000;
			frame_snap_reg <= 32'h0000_0000;
			errf_snap_reg <= 32'h0000_0000;
			bit_snap_reg <= 8'h00;
		end else if (snap_req) begin
			byte_snap_reg <= byte_live;
			frame_snap_reg <= frame_live;
			errf_snap_reg <= errf_live;
			bit_snap_reg <= bit_live;
		end
	end

	// Overflow flags: a new overflow wins over a coincident clear
	always_ff @(posedge clk) begin
		if (rst) begin
			frame_ovf_flag_reg <= 1'b0;
		end else if (frame_ovf) begin
			frame_ovf_flag_reg <= 1'b1;
		end else if (snap_clr) begin
			frame_ovf_flag_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			byte_ovf_flag_reg <= 1'b0;
		end else if (byte_ovf) begin
			byte_ovf_flag_reg <= 1'b1;
		end else if (snap_clr) begin
			byte_ovf_flag_reg <= 1'b0;
		end
	end

	// Pulse on any restart from zero in wrap mode
	always_ff @(posedge clk) begin
		if (rst) begin
			cnt_wrap_reg <= 1'b0;
		end else begin
			cnt_wrap_reg <= mode_reg &&
				(byte_ovf || frame_ovf || errf_ovf || bit_ovf);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lock_reg <= 1'b0;
			lock_d_reg <= 1'b0;
		end else begin
			lock_reg <= chk_evt.lock;
			lock_d_reg <= lock_reg;
		end
	end

	// Interrupt events
	always_comb begin
		irq_evt = '0;
		irq_evt[`PCC_IRQ_FRM_OVF] = frame_ovf;
		irq_evt[`PCC_IRQ_BYTE_OVF] = byte_ovf;
		irq_evt[`PCC_IRQ_ERRF_OVF] = errf_ovf;
		irq_evt[`PCC_IRQ_BIT_OVF] = bit_ovf;
		irq_evt[`PCC_IRQ_DONE] = done_rise;
		irq_evt[`PCC_IRQ_LOCK_UP] = lock_reg && !lock_d_reg;
		irq_evt[`PCC_IRQ_LOCK_DOWN] = !lock_reg && lock_d_reg;
	end

	assign irq_clr_mask = wr_irq_clr ? reg_wdata[`PCC_IRQ_W-1:0] : '0;

	// Set wins over a write-one clear in the same cycle
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~irq_clr_mask) | irq_evt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_en_reg <= '0;
		end else if (wr_irq_en) begin
			irq_en_reg <= reg_wdata[`PCC_IRQ_W-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_reg <= 1'b0;
		end else begin
			irq_reg <= |(irq_stat_reg & irq_en_reg);
		end
	end

	// Read mux; unmapped and write-only addresses read zero
	always_comb begin
		rd_next = 16'h0000;
		case (reg_addr)
			`PCC_OFF_CTRL: begin
				rd_next[`PCC_CTRL_SEND_BIT] = send_reg;
				rd_next[`PCC_CTRL_MODE_BIT] = mode_reg;
				rd_next[`PCC_CTRL_CHK_EN_BIT] = chk_en_reg;
			end
			`PCC_OFF_GAP: begin
				rd_next[7:0] = gap_reg;
			end
			`PCC_OFF_BYTES: begin
				rd_next = byte_snap_reg;
			end
			`PCC_OFF_FRM_LO: begin
				rd_next = frame_snap_reg[15:0];
			end
			`PCC_OFF_FRM_HI: begin
				rd_next = frame_snap_reg[31:16];
			end
			`PCC_OFF_FLAGS: begin
				rd_next[`PCC_FLAG_DONE_BIT] = gen_done;
				rd_next[`PCC_FLAG_BUSY_BIT] = gen_busy;
				rd_next[`PCC_FLAG_FOV_BIT] = frame_ovf_flag_reg;
				rd_next[`PCC_FLAG_BOV_BIT] = byte_ovf_flag_reg;
				rd_next[`PCC_FLAG_LOCK_BIT] = lock_reg;
				rd_next[7:0] = bit_snap_reg;
			end
			`PCC_OFF_ERRF_LO: begin
				rd_next = errf_snap_reg[15:0];
			end
			`PCC_OFF_ERRF_HI: begin
				rd_next = errf_snap_reg[31:16];
			end
			`PCC_OFF_IRQ_STAT: begin
				rd_next[`PCC_IRQ_W-1:0] = irq_stat_reg;
			end
			`PCC_OFF_IRQ_EN: begin
				rd_next[`PCC_IRQ_W-1:0] = irq_en_reg;
			end
			default: begin
				rd_next = 16'h0000;
			end
		endcase
	end

	// Data stand only in the cycle after the strobe
	always_ff @(posedge clk) begin
		if (rst) begin
			reg_rdata_reg <= 16'h0000;
		end else if (reg_rd) begin
			reg_rdata_reg <= rd_next;
		end else begin
			reg_rdata_reg <= 16'h0000;
		end
	end
endmodule: pcc_checker_status

// ---- verification/pcc_checker_status_assertions.sv ----
`timescale 1ns/1ps

module pcc_status_sva (
	input logic clk,
	input logic rst,
	input logic [11:0] reg_addr,
	input logic [15:0] reg_wdata,
	input logic reg_wr,
	input logic reg_rd,
	input logic [15:0] reg_rdata_reg,
	input pcc_pkg::pcc_chk_evt_t chk_evt,
	input pcc_pkg::pcc_gen_cfg_t gen_cfg,
	input logic tx_byte_ready,
	input logic tx_byte_valid_reg,
	input logic tx_byte_last_reg,
	input logic cnt_wrap_reg,
	input logic irq_reg
);
	logic mode_reg;
	logic gap_on_reg;
	logic [7:0] gap_reg;
	logic [15:0] idle_reg;
	logic ctl_wr;
	logic cnt_rd;
	assign ctl_wr = reg_wr && reg_addr == 12'h619;
	// Lock at 0x620 is live, so only pure counter reads must repeat
	assign cnt_rd = reg_rd && reg_addr != 12'h620 &&
		reg_addr inside {[12'h61c:12'h623]};

	always_ff @(posedge clk) begin
		if (rst) begin
			mode_reg <= 1'b0;
			gap_reg <= 8'h7d;
		end else if (ctl_wr) begin
			mode_reg <= reg_wdata[3];
		end else if (reg_wr && reg_addr == 12'h61b) begin
			gap_reg <= reg_wdata[7:0];
		end
	end

	// Idle cycles since the last byte of a frame was taken
	always_ff @(posedge clk) begin
		if (rst || ctl_wr) begin
			gap_on_reg <= 1'b0;
			idle_reg <= 16'h0000;
		end else if (tx_byte_valid_reg && tx_byte_ready && tx_byte_last_reg) begin
			gap_on_reg <= 1'b1;
			idle_reg <= 16'h0000;
		end else if (tx_byte_valid_reg) begin
			gap_on_reg <= 1'b0;
		end else if (gap_on_reg) begin
			idle_reg <= idle_reg + 16'h0001;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	a_rdata_idle: assert property (!reg_rd |=> reg_rdata_reg == 16'h0000)
		else $error("read data without read");
	a_snap_stable: assert property (
		cnt_rd ##1 cnt_rd && $stable(reg_addr) |=> $stable(reg_rdata_reg))
		else $error("snapshot changed");
	a_gap_length: assert property (
		gap_on_reg && tx_byte_valid_reg |-> idle_reg == {8'h00, gap_reg})
		else $error("gap length wrong");
	a_valid_hold: assert property (tx_byte_valid_reg && !tx_byte_ready &&
		!reg_wr && !$past(reg_wr) |=> tx_byte_valid_reg)
		else $error("byte dropped");
	a_last_valid: assert property (tx_byte_last_reg |-> tx_byte_valid_reg)
		else $error("last without valid");
	a_irq_fall: assert property ($fell(irq_reg) |-> $past(reg_wr, 2))
		else $error("irq fell without write");
	a_wrap_once: assert property (cnt_wrap_reg |=> !cnt_wrap_reg)
		else $error("wrap pulse too long");
	a_sat_quiet: assert property (
		!mode_reg && !$past(mode_reg) |-> !cnt_wrap_reg)
		else $error("wrap pulse in hold mode");

	c_wrap: cover property (cnt_wrap_reg);
	c_irq: cover property ($rose(irq_reg));
	c_gap: cover property (gap_on_reg && tx_byte_valid_reg);
endmodule: pcc_status_sva

bind pcc_checker_status pcc_status_sva u_sva (.clk(clk), .rst(rst),
	.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
	.reg_rd(reg_rd), .reg_rdata_reg(reg_rdata_reg), .chk_evt(chk_evt),
	.gen_cfg(gen_cfg), .tx_byte_ready(tx_byte_ready),
	.tx_byte_valid_reg(tx_byte_valid_reg),
	.tx_byte_last_reg(tx_byte_last_reg), .cnt_wrap_reg(cnt_wrap_reg),
	.irq_reg(irq_reg));

// ---- verification/tb.sv ----
`timescale 1ns/1ps

module tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [11:0] reg_addr = 12'h000;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata_reg;
	pcc_pkg::pcc_chk_evt_t chk_evt = '0;
	pcc_pkg::pcc_gen_cfg_t gen_cfg = '0;
	logic tx_byte_ready = 1'b1;
	logic tx_byte_valid_reg;
	logic tx_byte_last_reg;
	logic cnt_wrap_reg;
	logic irq_reg;
	logic [15:0] d;
	logic [11:0] zero_at [9] = '{12'h61c, 12'h61d, 12'h61e, 12'h620,
		12'h622, 12'h623, 12'h621, 12'h630, 12'h632};
	int n_fail = 0;
	int tests_run = 0;
	int n_take = 0;
	int n_last = 0;
	int n_wrap = 0;

	pcc_checker_status dut (.clk(clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata_reg(reg_rdata_reg), .chk_evt(chk_evt),
		.gen_cfg(gen_cfg), .tx_byte_ready(tx_byte_ready),
		.tx_byte_valid_reg(tx_byte_valid_reg),
		.tx_byte_last_reg(tx_byte_last_reg),
		.cnt_wrap_reg(cnt_wrap_reg), .irq_reg(irq_reg));

	initial begin
		forever #12.5 clk = ~clk;
	end

	always @(posedge clk) begin
		if (tx_byte_valid_reg === 1'b1 && tx_byte_ready) begin
			n_take++;
			n_last += tx_byte_last_reg;
		end
		if (cnt_wrap_reg === 1'b1)
			n_wrap++;
	end

	task automatic close_out;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask: close_out

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask: chk

	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask: wr

	task automatic rd(input logic [11:0] a, output logic [15:0] v);
		@(posedge clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 v = reg_rdata_reg;
	endtask: rd

	task automatic rc(input logic [11:0] a, input logic [15:0] m,
		input logic [15:0] e, input string nm);
		rd(a, d);
		chk(nm, e, d & m);
	endtask: rc

	// Holds checker events for n cycles, so n counts land
	task automatic ev(input pcc_pkg::pcc_chk_evt_t e, input int n);
		@(posedge clk);
		chk_evt <= e;
		repeat (n) @(posedge clk);
		chk_evt <= '0;
	endtask: ev

	// Interrupt output lags its status by one register
	task automatic irq_is(input logic e);
		repeat (2) @(posedge clk);
		#1 chk("irq", {15'h0000, e}, {15'h0000, irq_reg});
	endtask: irq_is

	initial begin
		repeat (100000) @(posedge clk);
		n_fail++;
		close_out;
	end

	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		foreach (zero_at[i])
			rc(zero_at[i], 16'hffff, 16'h0000, "reset");
		rc(12'h61b, 16'hffff, 16'h007d, "gap reset");
		wr(12'h61b, 16'hab03);
		rc(12'h61b, 16'hffff, 16'h0003, "gap");
		ev(5'h10, 10);
		ev(5'h08, 3);
		ev(5'h0c, 2);
		ev(5'h02, 3);
		rc(12'h61c, 16'hffff, 16'h0000, "bytes early");
		wr(12'h620, 16'h0001);
		rc(12'h61c, 16'hffff, 16'h000a, "bytes");
		rc(12'h61d, 16'hffff, 16'h0005, "frames lo");
		rc(12'h61e, 16'hffff, 16'h0000, "frames hi");
		rc(12'h622, 16'hffff, 16'h0002, "err frames");
		rc(12'h620, 16'h00ff, 16'h0003, "bit errors");
		ev(5'h10, 2);
		rc(12'h61c, 16'hffff, 16'h000a, "bytes held");
		wr(12'h620, 16'h0001);
		rc(12'h61c, 16'hffff, 16'h000c, "bytes again");
		wr(12'h620, 16'h0002);
		rc(12'h61c, 16'hffff, 16'h000c, "bytes at clear");
		wr(12'h620, 16'h0001);
		rc(12'h61c, 16'hffff, 16'h0000, "bytes cleared");
		@(posedge clk);
		chk_evt <= 5'h01;
		rc(12'h620, 16'h0100, 16'h0100, "lock");
		@(posedge clk);
		chk_evt <= 5'h00;
		rc(12'h620, 16'h0100, 16'h0000, "lock lost");
		wr(12'h619, 16'h0000);
		ev(5'h10, 4);
		wr(12'h620, 16'h0001);
		rc(12'h61c, 16'hffff, 16'h0000, "bytes disabled");
		wr(12'h619, 16'h0004);
		ev(5'h02, 300);
		wr(12'h620, 16'h0001);
		rc(12'h620, 16'h00ff, 16'h00ff, "bit errors held");
		// Back to back reads while live bytes advance must repeat
		@(posedge clk);
		chk_evt <= 5'h10;
		reg_rd <= 1'b1;
		reg_addr <= 12'h61c;
		repeat (2) @(posedge clk);
		chk_evt <= 5'h00;
		reg_rd <= 1'b0;
		#1 chk("bytes twice", 16'h0000, reg_rdata_reg);
		wr(12'h620, 16'h0002);
		wr(12'h619, 16'h000c);
		ev(5'h02, 257);
		wr(12'h620, 16'h0001);
		rc(12'h620, 16'h00ff, 16'h0001, "bit errors wrap");
		chk("wraps", 16'h0001, 16'(n_wrap));
		wr(12'h619, 16'h0004);
		wr(12'h620, 16'h0002);
		wr(12'h631, 16'h0002);
		ev(5'h10, 65540);
		wr(12'h620, 16'h0001);
		rc(12'h61c, 16'hffff, 16'hffff, "bytes full");
		rc(12'h620, 16'h0200, 16'h0200, "byte ovf");
		irq_is(1'b1);
		wr(12'h631, 16'h0000);
		irq_is(1'b0);
		wr(12'h631, 16'h0002);
		irq_is(1'b1);
		wr(12'h632, 16'h0002);
		irq_is(1'b0);
		rc(12'h630, 16'h0002, 16'h0000, "irq status");
		wr(12'h620, 16'h0002);
		rc(12'h620, 16'h0200, 16'h0000, "byte ovf clear");
		@(posedge clk);
		gen_cfg <= 32'h0002_0002;
		tx_byte_ready <= 1'b0;
		wr(12'h619, 16'h1004);
		for (int i = 0; i < 8 && tx_byte_valid_reg !== 1'b1; i++)
			@(posedge clk);
		chk("start", 16'h0001, {15'h0000, tx_byte_valid_reg});
		rc(12'h620, 16'h1800, 16'h0800, "busy");
		@(posedge clk);
		tx_byte_ready <= 1'b1;
		d = 16'h0000;
		for (int i = 0; i < 40 && d[12] !== 1'b1; i++)
			rd(12'h620, d);
		chk("done", 16'h1000, d & 16'h1800);
		rc(12'h619, 16'hffff, 16'h0004, "send");
		rc(12'h630, 16'h0010, 16'h0010, "done irq");
		chk("bytes sent", 16'h0004, 16'(n_take));
		chk("frame ends", 16'h0002, 16'(n_last));
		close_out;
	end
endmodule: tb
